/* rtl/uiem_top.sv */
// USB interrupt enable masks, source flags and active-low request pin
//
// Functional notes
// - Bit 15 gates VBUS change onto request
// - Bit 13 gates frame number update
// - Bit 12 gates device state transition
// - Bit 11 gates control stage transition
// - Bits 10,9,8 gate empty, not-ready, ready
// - Port0 bit 15 gates overcurrent
// - Port0 bit 14 gates bus change
// - Port0 bit 12 gates detach, host only
// - Port0 bit 11 gates attach
// - Port0 bit 6 gates end-of-frame error
// - Port0 bit 5 gates setup error
// - Port0 bit 4 gates setup acknowledge
// - Request pin low while enabled source pending
// - Flags set regardless of enable bits
// - Enabling a pending flag asserts request immediately
`timescale 1ns/10ps
`include "uiem_params.svh"

module uiem_top #(
  parameter int ADDR_WIDTH = 7,
  parameter int DATA_WIDTH = 16
) (
  // Clock and synchronous reset
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // CPU register bus
  input  wire logic [ADDR_WIDTH-1:0] cpu_addr,
  input  wire logic                  cpu_wr,
  input  wire logic                  cpu_rd,
  input  wire logic [DATA_WIDTH-1:0] cpu_wdata,
  output logic      [DATA_WIDTH-1:0] cpu_rdata,
  // Function select; high means host
  input  wire logic                  host_mode,
  // Detection pulses, one per source
  input  wire logic                  vbus_change_event,
  input  wire logic                  resume_event,
  input  wire logic                  frame_number_update_event,
  input  wire logic                  device_state_change_event,
  input  wire logic                  control_stage_change_event,
  input  wire logic                  buffer_empty_event,
  input  wire logic                  not_ready_response_event,
  input  wire logic                  buffer_ready_event,
  input  wire logic                  port0_overcurrent_event,
  input  wire logic                  port0_bus_change_event,
  input  wire logic                  port0_detach_event,
  input  wire logic                  port0_attach_event,
  input  wire logic                  port0_frame_end_error_event,
  input  wire logic                  port0_setup_error_event,
  input  wire logic                  port0_setup_ack_event,
  // Per-bit flag clears from the status side
  input  wire logic [DATA_WIDTH-1:0] general_flag_clear,
  input  wire logic [DATA_WIDTH-1:0] port0_flag_clear,
  // Sticky flags and the request pin
  output logic      [DATA_WIDTH-1:0] general_irq_flags,
  output logic      [DATA_WIDTH-1:0] port0_irq_flags,
  output logic                       irq_n
);

  // The register layout is fixed at 16 bits and needs the 0x32 offset
  if (DATA_WIDTH != 16 || ADDR_WIDTH < 6) begin : g_bad_params
    $error("uiem_top: DATA_WIDTH must be 16 and ADDR_WIDTH at least 6");
  end

  // Field positions must match the implemented-bit masks, or a flag would be clipped away
  localparam uiem_pkg::uiem_word_t GENERAL_FIELDS = (16'h0001 << `UIEM_VBUS_BIT)
                                                  | (16'h0001 << `UIEM_RESUME_BIT)
                                                  | (16'h0001 << `UIEM_FRAME_BIT)
                                                  | (16'h0001 << `UIEM_DEVSTATE_BIT)
                                                  | (16'h0001 << `UIEM_CTRLSTAGE_BIT)
                                                  | (16'h0001 << `UIEM_BEMPTY_BIT)
                                                  | (16'h0001 << `UIEM_NOTREADY_BIT)
                                                  | (16'h0001 << `UIEM_BREADY_BIT);
  localparam uiem_pkg::uiem_word_t PORT0_FIELDS   = (16'h0001 << `UIEM_OVERCUR_BIT)
                                                  | (16'h0001 << `UIEM_BUSCHG_BIT)
                                                  | (16'h0001 << `UIEM_DETACH_BIT)
                                                  | (16'h0001 << `UIEM_ATTACH_BIT)
                                                  | (16'h0001 << `UIEM_FRAMEERR_BIT)
                                                  | (16'h0001 << `UIEM_SETUPERR_BIT)
                                                  | (16'h0001 << `UIEM_SETUPACK_BIT);
  if (GENERAL_FIELDS != `UIEM_GENERAL_VALID
      || PORT0_FIELDS != `UIEM_PORT0_VALID) begin : g_bad_fields
    $error("uiem_top: field positions disagree with the implemented-bit masks");
  end

  // Clip a word to the implemented bits so unassigned ones stay zero
  function automatic uiem_pkg::uiem_word_t clip(input uiem_pkg::uiem_word_t value,
                                                 input uiem_pkg::uiem_word_t valid);
    clip = value & valid;
  endfunction

  // Any flag whose enable is also set
  function automatic logic any_pending(input uiem_pkg::uiem_word_t flags,
                                       input uiem_pkg::uiem_word_t enables);
    any_pending = |(flags & enables);
  endfunction

  // One source's request: its flag and its enable both set
  function automatic logic source_live(input uiem_pkg::uiem_word_t flags,
                                       input uiem_pkg::uiem_word_t enables,
                                       input int                   pos);
    source_live = flags[pos] & enables[pos];
  endfunction

  // Byte address decode; bit 0 is ignored on the 16-bit bus
  function automatic uiem_pkg::uiem_sel_t decode(input logic [ADDR_WIDTH-1:0] addr);
    logic [ADDR_WIDTH-1:0] even;
    even = {addr[ADDR_WIDTH-1:1], 1'b0};
    if (even == ADDR_WIDTH'(`UIEM_GENERAL_EN_OFS)) begin
      decode = uiem_pkg::UIEM_SEL_GENERAL;
    end else if (even == ADDR_WIDTH'(`UIEM_PORT0_EN_OFS)) begin
      decode = uiem_pkg::UIEM_SEL_PORT0;
    end else begin
      decode = uiem_pkg::UIEM_SEL_NONE;
    end
  endfunction

  uiem_pkg::uiem_word_t general_irq_enable_mask;
  uiem_pkg::uiem_word_t port0_irq_enable_mask;
  uiem_pkg::uiem_word_t next_general_irq_enable_mask;
  uiem_pkg::uiem_word_t next_port0_irq_enable_mask;
  uiem_pkg::uiem_word_t next_general_irq_flags;
  uiem_pkg::uiem_word_t next_port0_irq_flags;
  uiem_pkg::uiem_word_t next_cpu_rdata;
  uiem_pkg::uiem_word_t general_set;
  uiem_pkg::uiem_word_t port0_set;
  uiem_pkg::uiem_word_t port0_gate;
  uiem_pkg::uiem_sel_t  sel;
  uiem_pkg::uiem_word_t general_live;
  uiem_pkg::uiem_word_t port0_live;
  logic                 next_irq_n;

  assign sel = decode(cpu_addr);

  // Event pulses placed at their flag positions
  always_comb begin
    general_set = '0;
    general_set[`UIEM_VBUS_BIT]      = vbus_change_event;
    general_set[`UIEM_RESUME_BIT]    = resume_event;
    general_set[`UIEM_FRAME_BIT]     = frame_number_update_event;
    general_set[`UIEM_DEVSTATE_BIT]  = device_state_change_event;
    general_set[`UIEM_CTRLSTAGE_BIT] = control_stage_change_event;
    general_set[`UIEM_BEMPTY_BIT]    = buffer_empty_event;
    general_set[`UIEM_NOTREADY_BIT]  = not_ready_response_event;
    general_set[`UIEM_BREADY_BIT]    = buffer_ready_event;
  end

  // Port 0 event pulses at their flag positions
  always_comb begin
    port0_set = '0;
    port0_set[`UIEM_OVERCUR_BIT]   = port0_overcurrent_event;
    port0_set[`UIEM_BUSCHG_BIT]    = port0_bus_change_event;
    port0_set[`UIEM_DETACH_BIT]    = port0_detach_event;
    port0_set[`UIEM_ATTACH_BIT]    = port0_attach_event;
    port0_set[`UIEM_FRAMEERR_BIT]  = port0_frame_end_error_event;
    port0_set[`UIEM_SETUPERR_BIT]  = port0_setup_error_event;
    port0_set[`UIEM_SETUPACK_BIT]  = port0_setup_ack_event;
  end

  // Sticky general flags; a set in the clear cycle wins so no event is lost
  always_comb begin
    next_general_irq_flags = clip((general_irq_flags & ~general_flag_clear) | general_set,
                                  `UIEM_GENERAL_VALID);
  end

  // Sticky port 0 flags, same set-wins rule
  always_comb begin
    next_port0_irq_flags   = clip((port0_irq_flags & ~port0_flag_clear) | port0_set,
                                  `UIEM_PORT0_VALID);
  end

  // General mask write; unassigned bits are never stored
  always_comb begin
    next_general_irq_enable_mask = general_irq_enable_mask;
    if (cpu_wr && sel == uiem_pkg::UIEM_SEL_GENERAL) begin
      next_general_irq_enable_mask = clip(cpu_wdata, `UIEM_GENERAL_VALID);
    end
  end

  // Port 0 mask write, clipped the same way
  always_comb begin
    next_port0_irq_enable_mask   = port0_irq_enable_mask;
    if (cpu_wr && sel == uiem_pkg::UIEM_SEL_PORT0) begin
      next_port0_irq_enable_mask = clip(cpu_wdata, `UIEM_PORT0_VALID);
    end
  end

  // Detach only counts in host function; the other enables trust software
  always_comb begin
    port0_gate = `UIEM_PORT0_VALID;
    port0_gate[`UIEM_DETACH_BIT] = host_mode;
  end

  // General request bits; one gate per enable keeps each source traceable
  always_comb begin
    uiem_pkg::uiem_word_t gf;
    uiem_pkg::uiem_word_t ge;
    gf = next_general_irq_flags;
    ge = next_general_irq_enable_mask;
    general_live = '0;
    general_live[`UIEM_VBUS_BIT]      = source_live(gf, ge, `UIEM_VBUS_BIT);
    general_live[`UIEM_RESUME_BIT]    = source_live(gf, ge, `UIEM_RESUME_BIT);
    general_live[`UIEM_FRAME_BIT]     = source_live(gf, ge, `UIEM_FRAME_BIT);
    general_live[`UIEM_DEVSTATE_BIT]  = source_live(gf, ge, `UIEM_DEVSTATE_BIT);
    general_live[`UIEM_CTRLSTAGE_BIT] = source_live(gf, ge, `UIEM_CTRLSTAGE_BIT);
    general_live[`UIEM_BEMPTY_BIT]    = source_live(gf, ge, `UIEM_BEMPTY_BIT);
    general_live[`UIEM_NOTREADY_BIT]  = source_live(gf, ge, `UIEM_NOTREADY_BIT);
    general_live[`UIEM_BREADY_BIT]    = source_live(gf, ge, `UIEM_BREADY_BIT);
  end

  // Port 0 request bits; detach passes only through the host gate
  always_comb begin
    uiem_pkg::uiem_word_t pf;
    uiem_pkg::uiem_word_t pe;
    pf = next_port0_irq_flags;
    pe = next_port0_irq_enable_mask & port0_gate;
    port0_live = '0;
    port0_live[`UIEM_OVERCUR_BIT]  = source_live(pf, pe, `UIEM_OVERCUR_BIT);
    port0_live[`UIEM_BUSCHG_BIT]   = source_live(pf, pe, `UIEM_BUSCHG_BIT);
    port0_live[`UIEM_DETACH_BIT]   = source_live(pf, pe, `UIEM_DETACH_BIT);
    port0_live[`UIEM_ATTACH_BIT]   = source_live(pf, pe, `UIEM_ATTACH_BIT);
    port0_live[`UIEM_FRAMEERR_BIT] = source_live(pf, pe, `UIEM_FRAMEERR_BIT);
    port0_live[`UIEM_SETUPERR_BIT] = source_live(pf, pe, `UIEM_SETUPERR_BIT);
    port0_live[`UIEM_SETUPACK_BIT] = source_live(pf, pe, `UIEM_SETUPACK_BIT);
  end

  // Request from next values, so enabling a pending flag acts at once
  // Taken from a flip-flop, so the pin cannot glitch during a mask write
  // Costs nothing in latency: the pin moves at the same edge as the flag
  always_comb begin
    next_irq_n = ~(any_pending(general_live, `UIEM_GENERAL_VALID)
                 | any_pending(port0_live, `UIEM_PORT0_VALID));
  end

  // Read data; unmapped offsets answer zero
  always_comb begin
    next_cpu_rdata = cpu_rdata;
    if (cpu_rd) begin
      case (sel)
        uiem_pkg::UIEM_SEL_GENERAL: next_cpu_rdata = general_irq_enable_mask;
        uiem_pkg::UIEM_SEL_PORT0:   next_cpu_rdata = port0_irq_enable_mask;
        uiem_pkg::UIEM_SEL_NONE:    next_cpu_rdata = '0;
        default:                    next_cpu_rdata = '0;
      endcase
    end
  end

  // General mask register; reset leaves every source disabled
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      general_irq_enable_mask <= `UIEM_GENERAL_EN_RST;
    end else begin
      general_irq_enable_mask <= next_general_irq_enable_mask;
    end
  end

  // Port 0 mask register; reset leaves every source disabled
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      port0_irq_enable_mask <= `UIEM_PORT0_EN_RST;
    end else begin
      port0_irq_enable_mask <= next_port0_irq_enable_mask;
    end
  end

  // General flag register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      general_irq_flags <= `UIEM_FLAGS_RST;
    end else begin
      general_irq_flags <= next_general_irq_flags;
    end
  end

  // Port 0 flag register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      port0_irq_flags <= `UIEM_FLAGS_RST;
    end else begin
      port0_irq_flags <= next_port0_irq_flags;
    end
  end

  // Read data register; holds the last read until the next strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cpu_rdata <= '0;
    end else begin
      cpu_rdata <= next_cpu_rdata;
    end
  end

  // Request pin register; released high in reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= next_irq_n;
    end
  end

  // Peripheral-only enables in host function are software's duty

endmodule

/* inc/uiem_params.svh */
// Offsets, field positions and reset values of the interrupt enable masks
`ifndef UIEM_PARAMS_SVH
`define UIEM_PARAMS_SVH

// Register byte offsets on the CPU bus
`define UIEM_GENERAL_EN_OFS     7'h30
`define UIEM_PORT0_EN_OFS       7'h32

// Field positions in the general enable mask and flags
`define UIEM_VBUS_BIT           15
`define UIEM_RESUME_BIT         14
`define UIEM_FRAME_BIT          13
`define UIEM_DEVSTATE_BIT       12
`define UIEM_CTRLSTAGE_BIT      11
`define UIEM_BEMPTY_BIT         10
`define UIEM_NOTREADY_BIT       9
`define UIEM_BREADY_BIT         8

// Field positions in the port 0 enable mask and flags
`define UIEM_OVERCUR_BIT        15
`define UIEM_BUSCHG_BIT         14
`define UIEM_DETACH_BIT         12
`define UIEM_ATTACH_BIT         11
`define UIEM_FRAMEERR_BIT       6
`define UIEM_SETUPERR_BIT       5
`define UIEM_SETUPACK_BIT       4

// Implemented bits; all others read as zero
`define UIEM_GENERAL_VALID      16'hff00
`define UIEM_PORT0_VALID        16'hd870

// Reset values: every source disabled, every flag clear
`define UIEM_GENERAL_EN_RST     16'h0000
`define UIEM_PORT0_EN_RST       16'h0000
`define UIEM_FLAGS_RST          16'h0000

`endif

/* inc/uiem_pkg.sv */
// Types shared by the interrupt enable mask block
package uiem_pkg;

  // One 16-bit register or flag word
  typedef logic [15:0] uiem_word_t;

  // Decoded register selected by a bus access
  typedef enum logic [2:0] {
    UIEM_SEL_NONE    = 3'b001,
    UIEM_SEL_GENERAL = 3'b010,
    UIEM_SEL_PORT0   = 3'b100
  } uiem_sel_t;

endpackage

/* tb/uiem_chk_assertions.sv */
// Port checker for the interrupt enable masks
`timescale 1ns/10ps
module uiem_chk (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [6:0]  cpu_addr,
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic [15:0] cpu_wdata,
  input wire logic [15:0] cpu_rdata,
  input wire logic        vbus_change_event,
  input wire logic        buffer_ready_event,
  input wire logic [15:0] general_irq_flags,
  input wire logic [15:0] port0_irq_flags,
  input wire logic        irq_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Request and flag relations
  property p_irq; !irq_n |-> (general_irq_flags | port0_irq_flags) != 16'h0000; endproperty
  a_irq: assert property (p_irq) else $error("request without flag");
  property p_rst; $past(srst) |-> irq_n && general_irq_flags == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_vbus; vbus_change_event |=> general_irq_flags[15]; endproperty
  a_vbus: assert property (p_vbus) else $error("vbus flag not set");
  property p_rdy; buffer_ready_event |=> general_irq_flags[8]; endproperty
  a_rdy: assert property (p_rdy) else $error("ready flag not set");
  property p_gap; (port0_irq_flags & 16'h278f) == 16'h0000 && general_irq_flags[7:0] == 8'h00;
  endproperty
  a_gap: assert property (p_gap) else $error("unassigned flag set");
  // Bus answers; a write followed by a read two cycles on must read back
  property p_unm; cpu_rd && cpu_addr[6:1] != 6'h18 && cpu_addr[6:1] != 6'h19
    |=> cpu_rdata == 16'h0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_low; cpu_rd && cpu_addr == 7'h30 |=> cpu_rdata[7:0] == 8'h00; endproperty
  a_low: assert property (p_low) else $error("low mask bits not zero");
  property p_wrd; (cpu_wr && !cpu_rd && cpu_addr == 7'h30) ##1 !cpu_wr ##1 (cpu_rd && !cpu_wr
    && cpu_addr == 7'h30) |=> cpu_rdata == ($past(cpu_wdata, 3) & 16'hff00); endproperty
  a_wrd: assert property (p_wrd) else $error("mask read back wrong");
endmodule

bind uiem_top uiem_chk u_chk (.*);

/* tb/uiem_src.sv */
// Event source standing in for the detection logic
`timescale 1ns/10ps
module uiem_src (
  input  wire logic [15:0] gev,
  input  wire logic [15:0] pev,
  output logic             vbus_change_event,
  output logic             resume_event,
  output logic             frame_number_update_event,
  output logic             device_state_change_event,
  output logic             control_stage_change_event,
  output logic             buffer_empty_event,
  output logic             not_ready_response_event,
  output logic             buffer_ready_event,
  output logic             port0_overcurrent_event,
  output logic             port0_bus_change_event,
  output logic             port0_detach_event,
  output logic             port0_attach_event,
  output logic             port0_frame_end_error_event,
  output logic             port0_setup_error_event,
  output logic             port0_setup_ack_event
);
  // Word bits sit where the flags sit, so one vector drives each group
  assign {vbus_change_event, resume_event, frame_number_update_event, device_state_change_event,
          control_stage_change_event, buffer_empty_event, not_ready_response_event,
          buffer_ready_event} = gev[15:8];
  assign {port0_overcurrent_event, port0_bus_change_event, port0_detach_event, port0_attach_event,
          port0_frame_end_error_event, port0_setup_error_event, port0_setup_ack_event}
         = {pev[15:14], pev[12:11], pev[6:4]};
endmodule

/* tb/tb.sv */
// Self-checking bench for the interrupt enable masks
`timescale 1ns/10ps
`include "uiem_params.svh"
module tb;
  logic        ref_clk, srst, cpu_wr, cpu_rd, host_mode, irq_n;
  logic [6:0]  cpu_addr, a;
  logic [15:0] cpu_wdata, general_flag_clear, port0_flag_clear, gev, pev, vm, p;
  logic [15:0] cpu_rdata, general_irq_flags, port0_irq_flags;
  wire logic   vbus_change_event, resume_event, frame_number_update_event, buffer_ready_event;
  wire logic   device_state_change_event, control_stage_change_event, buffer_empty_event;
  wire logic   not_ready_response_event, port0_overcurrent_event, port0_bus_change_event;
  wire logic   port0_detach_event, port0_attach_event, port0_frame_end_error_event;
  wire logic   port0_setup_error_event, port0_setup_ack_event;
  int          n_mismatch = 0;
  int          n_checks = 0;
  uiem_top u_dut (.*);
  uiem_src u_src (.*);
  always #2.5 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus cycle; the strobe drops after the edge that takes it
  task automatic acc(input logic [6:0] ad, input logic w, input logic [15:0] d);
    @(posedge ref_clk);
    {cpu_addr, cpu_wr, cpu_rd, cpu_wdata} <= {ad, w, !w, d};
    @(posedge ref_clk);
    {cpu_wr, cpu_rd} <= 2'b00;
    #1;
  endtask
  // One-cycle pulse on events and flag clears
  task automatic pulse(input logic [63:0] v);
    @(posedge ref_clk);
    {gev, pev, general_flag_clear, port0_flag_clear} <= v;
    @(posedge ref_clk);
    {gev, pev, general_flag_clear, port0_flag_clear} <= 64'h0;
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Cut a hang short well after the tests should finish
  initial begin
    #50000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    {ref_clk, srst, cpu_wr, cpu_rd, host_mode, cpu_addr, cpu_wdata} = 0;
    {gev, pev, general_flag_clear, port0_flag_clear} = 64'h0;
    srst = 1'b1;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    acc(7'h30, 1'b0, 16'h0000);
    chk("general mask", 16'h0000, cpu_rdata);
    chk("irq reset", 16'h0001, {15'h0, irq_n});
    acc(7'h34, 1'b1, 16'hffff);
    acc(7'h34, 1'b0, 16'h0000);
    chk("unmapped", 16'h0000, cpu_rdata);
    $display("reset and unmapped test done");
    // Peripheral-only enables are used only with host mode low
    for (int r = 0; r < 2; r++) begin
      @(posedge ref_clk);
      host_mode <= (r == 1);
      vm = r ? `UIEM_PORT0_VALID : `UIEM_GENERAL_VALID;
      a = r ? 7'h32 : 7'h30;
      acc(a, 1'b1, 16'hffff);
      acc(a, 1'b0, 16'h0000);
      chk("mask bits", vm, cpu_rdata);
      acc(a, 1'b1, 16'h0000);
      for (int i = 0; i < 16; i++) begin
        p = 16'h0001 << i;
        if (vm[i]) begin
          pulse(r ? {16'h0, p, 32'h0} : {p, 48'h0});
          chk("flag", p, r ? port0_irq_flags : general_irq_flags);
          chk("irq masked", 16'h0001, {15'h0, irq_n});
          acc(a, 1'b1, p);
          if (r == 0) chk("irq on", 16'h0, {15'h0, irq_n});
          else chk("irq on port0", 16'h0, {15'h0, irq_n});
          acc(a, 1'b1, 16'h0000);
          chk("irq off", 16'h0001, {15'h0, irq_n});
          pulse(r ? {48'h0, p} : {32'h0, p, 16'h0});
          chk("flag clear", 16'h0, r ? port0_irq_flags : general_irq_flags);
        end
      end
      $display("mask sweep test done");
    end
    // Detach counts only in host function
    @(posedge ref_clk);
    host_mode <= 1'b0;
    pulse({16'h0, 16'h1000, 32'h0});
    acc(7'h32, 1'b1, 16'h1000);
    chk("detach periph", 16'h0001, {15'h0, irq_n});
    @(posedge ref_clk);
    host_mode <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("detach host", 16'h0000, {15'h0, irq_n});
    $display("detach test done");
    // An event and its clear in one cycle leave the flag set
    pulse({16'h8000, 16'h0000, 16'h8000, 16'h0000});
    chk("set beats clear", 16'h8000, general_irq_flags);
    $display("set and clear test done");
    end_sim();
  end
endmodule
